//--- rsso_core.sv
// rsso_core: execution datapath for rotate, subtract-with-borrow and decrement-skip
`timescale 1ns/100ps
`default_nettype none
module rsso_core (
    // clock and reset
    input  wire logic                         mclk_i,
    input  wire logic                         srst_i,
    // operation request from the sequencer
    input  wire logic                         op_valid_i,
    input  wire rsso_pkg::rsso_req_s          op_req_i,
    output logic                              op_ready_o,
    // working register and flag load from the rest of the core
    input  wire logic                         work_load_i,
    input  wire logic [rsso_pkg::DATA_W-1:0]  work_load_data_i,
    input  wire logic                         flags_load_i,
    input  wire rsso_pkg::rsso_flags_s        flags_load_data_i,
    // results
    output logic                              done_o,
    output rsso_pkg::rsso_wr_s                mem_wr_o,
    output logic [rsso_pkg::DATA_W-1:0]       working_register_o,
    output rsso_pkg::rsso_flags_s             flags_o,
    output logic                              skip_o,
    output logic                              dummy_o
);

    // -------------------------------------------------------------------------
    // state
    // -------------------------------------------------------------------------
    logic [rsso_pkg::DATA_W-1:0] work_r;
    rsso_pkg::rsso_flags_s       flags_r;
    rsso_pkg::rsso_wr_s          wr_r;
    rsso_pkg::rsso_state_e       state_r;
    rsso_pkg::rsso_state_e       state_nxt;
    logic                        done_r;
    logic                        skip_r;

    // -------------------------------------------------------------------------
    // combinational results
    // -------------------------------------------------------------------------
    logic                        take;
    logic [rsso_pkg::DATA_W-1:0] m;
    logic [rsso_pkg::DATA_W-1:0] rot_plain;
    logic [rsso_pkg::DATA_W-1:0] rot_carry;
    logic [rsso_pkg::DATA_W:0]   diff_full;
    logic [rsso_pkg::NIB_W:0]    diff_nib;
    logic [rsso_pkg::DATA_W-1:0] diff;
    logic                        borrow_in;
    logic                        ovf;
    logic [rsso_pkg::DATA_W-1:0] dec;
    logic                        dec_null;
    rsso_pkg::rsso_flags_s       sub_flags;

    // a request is taken only outside the dummy cycle
    assign take       = op_valid_i && (state_r == rsso_pkg::ST_IDLE);
    assign op_ready_o = (state_r == rsso_pkg::ST_IDLE);
    assign m          = op_req_i.mem_byte;

    // plain rotate: old bit 0 lands in bit 7
    assign rot_plain = {m[rsso_pkg::LSB_POS], m[rsso_pkg::MSB_POS:rsso_pkg::LSB_POS+1]};

    // nine-bit rotate: old carry lands in bit 7
    assign rot_carry = {flags_r.carry, m[rsso_pkg::MSB_POS:rsso_pkg::LSB_POS+1]};

    // subtract with borrow: the borrow is the inverted carry
    assign borrow_in = ~flags_r.carry;
    assign diff_full = {1'b0, work_r} - {1'b0, m}
                     - {{rsso_pkg::DATA_W{1'b0}}, borrow_in};
    assign diff_nib  = {1'b0, work_r[rsso_pkg::NIB_W-1:0]} - {1'b0, m[rsso_pkg::NIB_W-1:0]}
                     - {{rsso_pkg::NIB_W{1'b0}}, borrow_in};
    assign diff      = diff_full[rsso_pkg::DATA_W-1:0];
    assign ovf       = (work_r[rsso_pkg::MSB_POS] ^ m[rsso_pkg::MSB_POS])
                     & (work_r[rsso_pkg::MSB_POS] ^ diff[rsso_pkg::MSB_POS]);

    // flags after a subtraction; carry is the complement of the borrow out
    always_comb
    begin
        sub_flags.signed_range_flag = ovf;
        sub_flags.zero              = (diff == rsso_pkg::NULL_BYTE);
        sub_flags.half_carry_flag   = ~diff_nib[rsso_pkg::NIB_W];
        sub_flags.carry             = ~diff_full[rsso_pkg::DATA_W];
    end

    // decrement for the skip operation
    assign dec      = m - rsso_pkg::ONE_BYTE;
    assign dec_null = (dec == rsso_pkg::NULL_BYTE);

    // -------------------------------------------------------------------------
    // working register
    // -------------------------------------------------------------------------
    // an operation result wins over an outside load in the same cycle
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            work_r <= rsso_pkg::WORK_RST;
        end
        else if (take)
        begin
            unique case (op_req_i.op)
                rsso_pkg::OP_ROTATE_RIGHT_TO_WORKING:         work_r <= rot_plain;
                rsso_pkg::OP_ROTATE_THRU_FLAG_TO_WORKING:     work_r <= rot_carry;
                rsso_pkg::OP_SUBTRACT_WITH_BORROW_TO_WORKING: work_r <= diff;
                default:                                      work_r <= work_r;
            endcase
        end
        else if (work_load_i)
        begin
            work_r <= work_load_data_i;
        end
    end

    // -------------------------------------------------------------------------
    // status flags
    // -------------------------------------------------------------------------
    // plain rotate and decrement-skip leave every flag alone
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            flags_r <= '0;
        end
        else if (take)
        begin
            unique case (op_req_i.op)
                rsso_pkg::OP_ROTATE_RIGHT_THRU_FLAG_MEM,
                rsso_pkg::OP_ROTATE_THRU_FLAG_TO_WORKING:
                    flags_r.carry <= m[rsso_pkg::LSB_POS];
                rsso_pkg::OP_SUBTRACT_WITH_BORROW_TO_WORKING,
                rsso_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM:
                    flags_r <= sub_flags;
                default:
                    flags_r <= flags_r;
            endcase
        end
        else if (flags_load_i)
        begin
            flags_r <= flags_load_data_i;
        end
    end

    // -------------------------------------------------------------------------
    // memory write-back
    // -------------------------------------------------------------------------
    // working-destination operations never raise the write strobe
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            wr_r <= '0;
        end
        else if (take)
        begin
            unique case (op_req_i.op)
                rsso_pkg::OP_ROTATE_RIGHT_THRU_FLAG_MEM:
                    wr_r <= '{mem_we: 1'b1, mem_wdata: rot_carry};
                rsso_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM:
                    wr_r <= '{mem_we: 1'b1, mem_wdata: diff};
                rsso_pkg::OP_DECREMENT_SKIP_ON_NULL:
                    wr_r <= '{mem_we: 1'b1, mem_wdata: dec};
                default:
                    wr_r <= '{mem_we: 1'b0, mem_wdata: wr_r.mem_wdata};
            endcase
        end
        else
        begin
            wr_r.mem_we <= 1'b0;
        end
    end

    // -------------------------------------------------------------------------
    // completion and skip
    // -------------------------------------------------------------------------
    // skip only when the decremented byte reaches zero
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            done_r <= 1'b0;
            skip_r <= 1'b0;
        end
        else
        begin
            done_r <= take;
            skip_r <= take && (op_req_i.op == rsso_pkg::OP_DECREMENT_SKIP_ON_NULL)
                      && dec_null;
        end
    end

    // -------------------------------------------------------------------------
    // sequencer: one dummy cycle after a taken skip
    // -------------------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            rsso_pkg::ST_IDLE:
            begin
                if (take && (op_req_i.op == rsso_pkg::OP_DECREMENT_SKIP_ON_NULL) && dec_null)
                begin
                    state_nxt = rsso_pkg::ST_DUMMY;
                end
            end
            rsso_pkg::ST_DUMMY:
            begin
                state_nxt = rsso_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = rsso_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            state_r <= rsso_pkg::ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    assign done_o             = done_r;
    assign mem_wr_o           = wr_r;
    assign working_register_o = work_r;
    assign flags_o            = flags_r;
    assign skip_o             = skip_r;
    assign dummy_o            = (state_r == rsso_pkg::ST_DUMMY);

endmodule : rsso_core
`default_nettype wire

//--- rsso_core_checker.sv
// rsso_core_checker: port assertions for rsso_core
`timescale 1ns/100ps
`default_nettype none
module rsso_core_checker (
    // clock, reset and inputs
    input wire logic                  mclk_i,
    input wire logic                  srst_i,
    input wire logic                  op_valid_i,
    input wire rsso_pkg::rsso_req_s   op_req_i,
    input wire logic                  work_load_i,
    input wire logic [7:0]            work_load_data_i,
    input wire logic                  flags_load_i,
    input wire rsso_pkg::rsso_flags_s flags_load_data_i,
    // outputs watched
    input wire logic                  op_ready_o,
    input wire logic                  done_o,
    input wire rsso_pkg::rsso_wr_s    mem_wr_o,
    input wire logic [7:0]            working_register_o,
    input wire rsso_pkg::rsso_flags_s flags_o,
    input wire logic                  skip_o,
    input wire logic                  dummy_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    logic [5:0] s;
    logic [7:0] m;
    logic [8:0] d;
    // one-hot decode of a taken op, and the expected borrow difference
    assign s = (op_valid_i && op_ready_o) ? 6'h01 << op_req_i.op : 6'h00;
    assign m = op_req_i.mem_byte;
    assign d = {1'b0, working_register_o} - {1'b0, m} - {8'h00, !flags_o.carry};
    property p_rot;
        s[0] |=> working_register_o == {$past(m[0]), $past(m[7:1])} && $stable(flags_o) && !mem_wr_o.mem_we;
    endproperty
    a_rot: assert property (p_rot) else $error("rotate to working wrong");
    property p_rrc;
        s[1] |=> mem_wr_o == {1'b1, $past(flags_o.carry), $past(m[7:1])} && flags_o.carry == $past(m[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate to memory wrong");
    property p_rotate_thru_flag_to_working;
        s[2] |=> working_register_o == {$past(flags_o.carry), $past(m[7:1])}
            && flags_o.carry == $past(m[0]) && !mem_wr_o.mem_we;
    endproperty
    a_rotate_thru_flag_to_working: assert property (p_rotate_thru_flag_to_working) else $error("rotate through carry wrong");
    property p_sbw;
        s[3] |=> working_register_o == $past(d[7:0]) && flags_o.zero == ($past(d[7:0]) == 8'h00);
    endproperty
    a_sbw: assert property (p_sbw) else $error("difference wrong");
    property p_brw;
        s[3] || s[4] |=> flags_o.carry == !$past(d[8]);
    endproperty
    a_brw: assert property (p_brw) else $error("borrow carry wrong");
    property p_sbm;
        s[4] |=> mem_wr_o == {1'b1, $past(d[7:0])} && $stable(working_register_o);
    endproperty
    a_sbm: assert property (p_sbm) else $error("difference to memory wrong");
    property p_sdz;
        s[5] |=> mem_wr_o == {1'b1, $past(m) - 8'h01} && skip_o == ($past(m) == 8'h01);
    endproperty
    a_sdz: assert property (p_sdz) else $error("decrement or skip wrong");
    property p_dmy;
        skip_o |-> dummy_o && !op_ready_o ##1 op_ready_o && !dummy_o;
    endproperty
    a_dmy: assert property (p_dmy) else $error("dummy cycle wrong");
endmodule : rsso_core_checker
bind rsso_core rsso_core_checker u_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .op_valid_i(op_valid_i), .op_req_i(op_req_i),
    .work_load_i(work_load_i), .work_load_data_i(work_load_data_i), .flags_load_i(flags_load_i),
    .flags_load_data_i(flags_load_data_i), .op_ready_o(op_ready_o), .done_o(done_o), .mem_wr_o(mem_wr_o),
    .working_register_o(working_register_o), .flags_o(flags_o), .skip_o(skip_o), .dummy_o(dummy_o)
);
`default_nettype wire

//--- rsso_mem_model.sv
// rsso_mem_model: data memory behind the datapath
`timescale 1ns/100ps
`default_nettype none
module rsso_mem_model (
    input  wire logic               mclk_i,
    input  wire logic               take_i,
    input  wire logic [2:0]         addr_i,
    input  wire rsso_pkg::rsso_wr_s wr_i,
    output logic [7:0]              rdata_o
);
    logic [7:0] mem [8];
    logic [2:0] addr_r;
    // addressed byte is read at once
    assign rdata_o = mem[addr_i];
    // write-back lands one cycle after the take, at the byte addressed at the take
    always @(posedge mclk_i)
    begin
        if (take_i) addr_r <= addr_i;
        if (wr_i.mem_we) mem[addr_r] <= wr_i.mem_wdata;
    end
endmodule : rsso_mem_model
`default_nettype wire

//--- rsso_pkg.sv
// rsso_pkg: shared constants and types for the rotate/subtract/skip datapath
`default_nettype none
package rsso_pkg;

    // -------------------------------------------------------------------------
    // widths and field positions
    // -------------------------------------------------------------------------
    localparam int unsigned DATA_W  = 8;            // byte width
    localparam int unsigned NIB_W   = 4;            // nibble width for half carry
    localparam int unsigned MSB_POS = DATA_W - 1;   // bit 7
    localparam int unsigned LSB_POS = 0;            // bit 0

    // -------------------------------------------------------------------------
    // reset value and byte constants
    // -------------------------------------------------------------------------
    localparam logic [DATA_W-1:0] WORK_RST = 8'h00;
    localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
    localparam logic [DATA_W-1:0] NULL_BYTE = 8'h00;

    // -------------------------------------------------------------------------
    // operation codes
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ROTATE_RIGHT_TO_WORKING        = 3'h0,
        OP_ROTATE_RIGHT_THRU_FLAG_MEM     = 3'h1,
        OP_ROTATE_THRU_FLAG_TO_WORKING    = 3'h2,
        OP_SUBTRACT_WITH_BORROW_TO_WORKING = 3'h3,
        OP_SUBTRACT_WITH_BORROW_TO_MEM    = 3'h4,
        OP_DECREMENT_SKIP_ON_NULL         = 3'h5
    } rsso_op_e;

    // -------------------------------------------------------------------------
    // sequencer states, one-hot
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h1,
        ST_DUMMY = 2'h2
    } rsso_state_e;

    // -------------------------------------------------------------------------
    // carriers
    // -------------------------------------------------------------------------
    typedef struct packed {
        logic signed_range_flag;
        logic zero;
        logic half_carry_flag;
        logic carry;
    } rsso_flags_s;

    typedef struct packed {
        rsso_op_e          op;
        logic [DATA_W-1:0] mem_byte;
    } rsso_req_s;

    typedef struct packed {
        logic              mem_we;
        logic [DATA_W-1:0] mem_wdata;
    } rsso_wr_s;

endpackage : rsso_pkg
`default_nettype wire

//--- tb_rotate_subtract_skip_ops.sv
// tb_rotate_subtract_skip_ops: scenario bench for rsso_core
`timescale 1ns/100ps
`default_nettype none
module tb_rotate_subtract_skip_ops;
    logic                  mclk_i = 1'b0, srst_i = 1'b1, vld = 1'b0, wl = 1'b0, fl = 1'b0;
    logic                  rdy, done, skp, dmy;
    logic [2:0]            addr = 3'h0;
    logic [7:0]            wd = 8'h00, rd, wk;
    rsso_pkg::rsso_op_e    op = rsso_pkg::OP_ROTATE_RIGHT_TO_WORKING;
    rsso_pkg::rsso_flags_s fd = 4'h0, fo;
    rsso_pkg::rsso_wr_s    wr;
    int                    n_fail = 0, checks_done = 0, cyc = 0;
    // clock and design
    always #5 mclk_i = ~mclk_i;
    rsso_core uut (.mclk_i(mclk_i), .srst_i(srst_i), .op_valid_i(vld), .op_req_i({op, rd}), .op_ready_o(rdy),
        .work_load_i(wl), .work_load_data_i(wd), .flags_load_i(fl), .flags_load_data_i(fd), .done_o(done),
        .mem_wr_o(wr), .working_register_o(wk), .flags_o(fo), .skip_o(skp), .dummy_o(dmy));
    rsso_mem_model mdl (.mclk_i(mclk_i), .take_i(vld && rdy), .addr_i(addr), .wr_i(wr), .rdata_o(rd));
    task automatic test_done();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        checks_done++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // memory byte, working register and flags set up and loaded in one cycle; no op issued
    task automatic prep(input logic [2:0] a, input logic [7:0] m, input logic [7:0] w, input logic [3:0] f);
        mdl.mem[a] = m;
        addr = a;
        wd = w;
        fd = f;
        {wl, fl} = 2'b11;
        @(negedge mclk_i);
        {wl, fl} = 2'b00;
    endtask : prep
    task automatic issue(input rsso_pkg::rsso_op_e o);
        op = o;
        vld = 1'b1;
        @(negedge mclk_i);
        vld = 1'b0;
    endtask : issue
    task automatic t_rot();
        prep(3'h0, 8'h01, 8'h00, 4'ha);
        issue(rsso_pkg::OP_ROTATE_RIGHT_TO_WORKING);
        chk({done, wr.mem_we, fo, wk}, {2'b10, 4'ha, 8'h80});
    endtask : t_rot
    task automatic t_rrc();
        prep(3'h1, 8'h02, 8'h00, 4'h1);
        issue(rsso_pkg::OP_ROTATE_RIGHT_THRU_FLAG_MEM);
        chk({wr, fo.carry}, {1'b1, 8'h81, 1'b0});
        @(negedge mclk_i);
        chk(mdl.mem[1], 8'h81);
    endtask : t_rrc
    task automatic t_rotate_thru_flag_to_working();
        prep(3'h2, 8'h02, 8'hff, 4'h1);
        issue(rsso_pkg::OP_ROTATE_THRU_FLAG_TO_WORKING);
        chk(wk, 8'h81);
        @(negedge mclk_i);
        chk({mdl.mem[2], fo.carry}, {8'h02, 1'b0});
    endtask : t_rotate_thru_flag_to_working
    task automatic t_sbc();
        logic [7:0] w [4] = '{8'h05, 8'h03, 8'h05, 8'h80};
        logic [7:0] m [4] = '{8'h03, 8'h05, 8'h05, 8'h7f};
        logic       c [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic [8:0] d;
        logic [4:0] h;
        for (int i = 0; i < 4; i++)
        begin
            d = {1'b0, w[i]} - {1'b0, m[i]} - {8'h00, !c[i]};
            h = {1'b0, w[i][3:0]} - {1'b0, m[i][3:0]} - {4'h0, !c[i]};
            prep(3'h3, m[i], w[i], {3'h0, c[i]});
            issue(rsso_pkg::OP_SUBTRACT_WITH_BORROW_TO_WORKING);
            chk(wk, d[7:0]);
            chk(fo, {w[i][7] != m[i][7] && d[7] != w[i][7], d[7:0] == 8'h00, !h[4], !d[8]});
        end
    endtask : t_sbc
    task automatic t_subtract_with_borrow_to_mem();
        prep(3'h4, 8'h02, 8'h01, 4'h1);
        issue(rsso_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEM);
        chk({wr, wk, fo.carry}, {1'b1, 8'hff, 8'h01, 1'b0});
    endtask : t_subtract_with_borrow_to_mem
    // skip taken, a request in the dummy cycle refused, then a plain decrement
    task automatic t_sdz();
        prep(3'h5, 8'h01, 8'h33, 4'h0);
        op = rsso_pkg::OP_DECREMENT_SKIP_ON_NULL;
        vld = 1'b1;
        @(negedge mclk_i);
        op = rsso_pkg::OP_ROTATE_RIGHT_TO_WORKING;
        chk({skp, dmy, rdy, wr}, {3'b110, 1'b1, 8'h00});
        @(negedge mclk_i);
        vld = 1'b0;
        chk({rdy, dmy, done, wk}, {3'b100, 8'h33});
        prep(3'h5, 8'h02, 8'h33, 4'h0);
        issue(rsso_pkg::OP_DECREMENT_SKIP_ON_NULL);
        chk({skp, dmy, rdy, wr}, {3'b001, 1'b1, 8'h01});
        @(negedge mclk_i);
        chk(mdl.mem[5], 8'h01);
    endtask : t_sdz
    // cycle ceiling against a hang
    always @(posedge mclk_i)
    begin
        cyc++;
        if (cyc == 500)
        begin
            n_fail++;
            test_done();
        end
    end
    // reset, then the scenarios in turn
    initial
    begin
        repeat (20) @(negedge mclk_i);
        srst_i = 1'b0;
        t_rot();
        t_rrc();
        t_rotate_thru_flag_to_working();
        t_sbc();
        t_subtract_with_borrow_to_mem();
        t_sdz();
        test_done();
    end
endmodule : tb_rotate_subtract_skip_ops
`default_nettype wire
